// [verilog/ppc_pkg.sv]
// Shared constants and types of the serial EEPROM power and protection control.
package ppc_pkg;
  // Clock and modify-cycle timing.
  localparam int PPC_CLK_HZ = 10_000_000;
  localparam int PPC_MODIFY_TIME_US = 1000;
  localparam int PPC_MODIFY_CYCLES = PPC_MODIFY_TIME_US * (PPC_CLK_HZ / 1_000_000);
  // Pin indices into the synchroniser vector.
  localparam int PPC_PIN_COUNT = 5;
  localparam int PPC_PIN_CS = 0;
  localparam int PPC_PIN_SCLK = 1;
  localparam int PPC_PIN_SDI = 2;
  localparam int PPC_PIN_PAUSE = 3;
  localparam int PPC_PIN_WP = 4;
  // Widths.
  localparam int PPC_ADDR_W = 21;
  localparam int PPC_CNT_W = 13;
  localparam int PPC_NV_W = 5;
  // Instruction codes.
  localparam logic [7:0] PPC_OP_WRSR = 8'h01;
  localparam logic [7:0] PPC_OP_WRITE = 8'h02;
  localparam logic [7:0] PPC_OP_READ = 8'h03;
  localparam logic [7:0] PPC_OP_WRDI = 8'h04;
  localparam logic [7:0] PPC_OP_RDSR = 8'h05;
  localparam logic [7:0] PPC_OP_SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] PPC_OP_ERASE = 8'h20;
  localparam logic [7:0] PPC_OP_CLRF = 8'h50;
  localparam logic [7:0] PPC_OP_SRST = 8'h99;
  localparam logic [7:0] PPC_OP_REL = 8'hab;
  localparam logic [7:0] PPC_OP_DPD = 8'hb9;
  // Frame lengths in serial clock pulses.
  localparam logic [PPC_CNT_W-1:0] PPC_LEN_SHORT = 13'h0008;
  localparam logic [PPC_CNT_W-1:0] PPC_LEN_WRSR = 13'h0010;
  localparam logic [PPC_CNT_W-1:0] PPC_LEN_ERASE = 13'h0020;
  localparam logic [PPC_CNT_W-1:0] PPC_LEN_WRITE_MIN = 13'h0028;
  // Bit counts after which a byte of the frame is complete.
  localparam logic [PPC_CNT_W-1:0] PPC_CNT_OPCODE = 13'h0007;
  localparam logic [PPC_CNT_W-1:0] PPC_CNT_BYTE2 = 13'h000f;
  localparam logic [PPC_CNT_W-1:0] PPC_CNT_BYTE3 = 13'h0017;
  localparam logic [PPC_CNT_W-1:0] PPC_CNT_BYTE4 = 13'h001f;
  // Block-guard codes.
  localparam logic [2:0] PPC_GUARD_NONE = 3'h0;
  localparam logic [2:0] PPC_GUARD_WIDE = 3'h6;
  localparam int PPC_GUARD_TOP_BITS = 6;
  // Status byte field positions.
  localparam int PPC_ST_LOCK = 7;
  localparam int PPC_ST_LOW_END = 6;
  localparam int PPC_ST_GUARD_HI = 4;
  localparam int PPC_ST_GUARD_LO = 2;
  localparam int PPC_ST_WEL = 1;
  localparam int PPC_ST_BUSY = 0;
  // Reset values of the volatile bits.
  localparam logic PPC_WEL_RST = 1'b0;
  localparam logic PPC_BUSY_RST = 1'b0;
  localparam logic PPC_FLAG_RST = 1'b0;
  localparam logic PPC_BUF_LOAD_RST = 1'b1;

  typedef enum logic [1:0] {
    PPC_SEQ_IDLE = 2'b00,
    PPC_SEQ_SHIFT = 2'b01,
    PPC_SEQ_IGNORE = 2'b11
  } ppc_seq_t;

  typedef enum logic [1:0] {
    PPC_PWR_STANDBY = 2'b00,
    PPC_PWR_ACTIVE = 2'b01,
    PPC_PWR_DEEP = 2'b11
  } ppc_pwr_t;

  typedef enum logic [1:0] {
    PPC_KIND_WRITE = 2'b00,
    PPC_KIND_ERASE = 2'b01,
    PPC_KIND_STATUS = 2'b11
  } ppc_kind_t;
endpackage : ppc_pkg

// [verilog/ppc_guard_if.sv]
// Link between the controller and its block-guard decoder.
interface ppc_guard_if;
  logic [2:0] block_guard;
  logic guard_from_low_end;
  logic [20:0] target_addr;
  logic target_guarded;
  logic erase_allowed;

  modport ctrl (
    output block_guard,
    output guard_from_low_end,
    output target_addr,
    input target_guarded,
    input erase_allowed
  );

  modport guard (
    input block_guard,
    input guard_from_low_end,
    input target_addr,
    output target_guarded,
    output erase_allowed
  );
endinterface : ppc_guard_if

// [verilog/ppc_pin_sync.sv]
// Two-stage synchronisers for the serial pins.
module ppc_pin_sync
  import ppc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [PPC_PIN_COUNT-1:0] pin_raw,
  output logic [PPC_PIN_COUNT-1:0] pin_sync
);
  logic [PPC_PIN_COUNT-1:0] stage_one;

  genvar g;
  generate
    for (g = 0; g < PPC_PIN_COUNT; g++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          // Reset to each pin's idle level so that no false edge follows reset.
          stage_one[g] <= (g != PPC_PIN_SCLK) && (g != PPC_PIN_SDI);
          pin_sync[g] <= (g != PPC_PIN_SCLK) && (g != PPC_PIN_SDI);
        end else begin
          stage_one[g] <= pin_raw[g];
          pin_sync[g] <= stage_one[g];
        end
      end
    end
  endgenerate
endmodule // ppc_pin_sync

// [verilog/ppc_guard.sv]
// Block-guard decoder: tells whether an address lies in the guarded region.
module ppc_guard
  import ppc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  ppc_guard_if.guard gif
);
  // A code of 1 to 5 guards 1/32 to 1/2 of the array: the top 6-code address bits
  // must all be one (upper end) or all zero (lower end).
  function automatic logic ppc_region_hit(input logic [PPC_ADDR_W-1:0] a,
                                          input logic [2:0] code, input logic low_end);
    logic hit;
    hit = 1'b1;
    if (code == PPC_GUARD_NONE) begin
      hit = 1'b0;
    end else if (code < PPC_GUARD_WIDE) begin
      for (int i = 0; i < PPC_GUARD_TOP_BITS - 1; i++) begin
        if (i < PPC_GUARD_TOP_BITS - int'(code)) begin
          hit = hit & (a[PPC_ADDR_W-1-i] == ~low_end);
        end
      end
    end
    return hit;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gif.target_guarded <= 1'b1;
      gif.erase_allowed <= 1'b0;
    end else begin
      gif.target_guarded <= ppc_region_hit(gif.target_addr, gif.block_guard,
                                           gif.guard_from_low_end);
      gif.erase_allowed <= (gif.block_guard == PPC_GUARD_NONE);
    end
  end
endmodule // ppc_guard

// [verilog/ppc_ctrl.sv]
// Power-state, pause and write-protection control of a serial page EEPROM.
module ppc_ctrl
  import ppc_pkg::*;
#(
  parameter int MODIFY_CYCLES = PPC_MODIFY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic write_protect_n,
  input wire logic [PPC_NV_W-1:0] nv_stored,
  input wire logic ecc_fix_one,
  input wire logic ecc_fix_two,
  input wire logic ecc_detect_three,
  output logic serial_out,
  output logic serial_out_oe,
  output logic [1:0] power_state,
  output logic write_enable_latch,
  output logic modify_busy,
  output logic block_guard_hi,
  output logic block_guard_mid,
  output logic block_guard_lo,
  output logic guard_from_low_end,
  output logic status_lock,
  output logic nv_store,
  output logic buffer_load_select,
  output logic guard_violation_flag,
  output logic ecc_one_flag,
  output logic ecc_two_flag,
  output logic ecc_three_flag,
  output logic ecc_pass_raw,
  output logic paused,
  output logic array_write_start,
  output logic array_erase_start,
  output logic [PPC_ADDR_W-1:0] array_addr
);
  logic [PPC_PIN_COUNT-1:0] pin_sync;
  logic s_cs_n, s_sclk, s_sdi, s_pause_n, s_wp_n;
  logic sclk_prev, cs_prev, cs_armed;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall, shift_rise;
  ppc_seq_t seq;
  ppc_pwr_t pwr;
  ppc_kind_t kind;
  logic [PPC_CNT_W-1:0] bit_cnt;
  logic [7:0] shreg, opcode, wrsr_data, status_byte;
  logic [7:0] next_byte;
  logic [PPC_ADDR_W-1:0] addr;
  logic wp_sampled, lock_sampled, read_on, rdsr_on;
  logic [31:0] mod_cnt;
  logic frame_end, len_ok, go, modify_ok, byte_refused, mod_done;
  logic do_set_write_latch_cmd, do_wrdi, do_dpd, do_rel, do_clr, do_srst;
  logic start_write, start_erase, start_wrsr, guard_hit;

  ppc_guard_if gif ();

  ppc_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_raw({write_protect_n, pause_n, serial_in, serial_clk, chip_sel_n}),
    .pin_sync(pin_sync)
  );

  ppc_guard u_guard (
    .clk_sys(clk_sys),
    .rst(rst),
    .gif(gif)
  );

  assign s_cs_n = pin_sync[PPC_PIN_CS];
  assign s_sclk = pin_sync[PPC_PIN_SCLK];
  assign s_sdi = pin_sync[PPC_PIN_SDI];
  assign s_pause_n = pin_sync[PPC_PIN_PAUSE];
  assign s_wp_n = pin_sync[PPC_PIN_WP];
  assign gif.block_guard = {block_guard_hi, block_guard_mid, block_guard_lo};
  assign gif.guard_from_low_end = guard_from_low_end;
  assign gif.target_addr = addr;

  assign sclk_rise = s_sclk & ~sclk_prev;
  assign sclk_fall = ~s_sclk & sclk_prev;
  assign cs_rise = s_cs_n & ~cs_prev;
  assign cs_fall = ~s_cs_n & cs_prev;
  // Clock edges count only while selected and not paused.
  assign shift_rise = sclk_rise & ~paused & (seq != PPC_SEQ_IDLE);
  assign next_byte = {shreg[6:0], s_sdi};
  assign mod_done = modify_busy & (mod_cnt == 32'(MODIFY_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sclk_prev <= s_sclk;
      cs_prev <= s_cs_n;
    end
  end

  // Selection needs chip select to have been seen high since power-up.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_armed <= 1'b0;
    end else if (s_cs_n) begin
      cs_armed <= 1'b1;
    end
  end

  // Pause tracking; deselection drops it.
  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      paused <= 1'b0;
    end else if (!paused && !s_pause_n && !s_sclk) begin
      paused <= 1'b1;
    end else if (paused && s_pause_n && !s_sclk) begin
      paused <= 1'b0;
    end
  end

  // A refused opcode puts the rest of the frame aside.
  assign byte_refused = ((pwr == PPC_PWR_DEEP) && (next_byte != PPC_OP_REL))
                        || (modify_busy && (next_byte != PPC_OP_RDSR));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq <= PPC_SEQ_IDLE;
    end else if (s_cs_n) begin
      seq <= PPC_SEQ_IDLE;
    end else begin
      case (seq)
        PPC_SEQ_IDLE: begin
          if (cs_fall && cs_armed) begin
            seq <= PPC_SEQ_SHIFT;
          end
        end
        PPC_SEQ_SHIFT: begin
          if (shift_rise && bit_cnt == PPC_CNT_OPCODE && byte_refused) begin
            seq <= PPC_SEQ_IGNORE;
          end
        end
        PPC_SEQ_IGNORE: seq <= PPC_SEQ_IGNORE;
        default: seq <= PPC_SEQ_IDLE;
      endcase
    end
  end

  // Bit counting and byte capture.
  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      bit_cnt <= '0;
      shreg <= 8'h00;
    end else if (shift_rise) begin
      bit_cnt <= bit_cnt + 13'h0001;
      shreg <= next_byte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      opcode <= 8'h00;
      wrsr_data <= 8'h00;
      addr <= '0;
      wp_sampled <= 1'b0;
      lock_sampled <= 1'b0;
    end else if (shift_rise) begin
      case (bit_cnt)
        PPC_CNT_OPCODE: opcode <= next_byte;
        PPC_CNT_BYTE2: begin
          wrsr_data <= next_byte;
          addr[PPC_ADDR_W-1:16] <= next_byte[PPC_ADDR_W-17:0];
          wp_sampled <= s_wp_n;
          lock_sampled <= status_lock;
        end
        PPC_CNT_BYTE3: addr[15:8] <= next_byte;
        PPC_CNT_BYTE4: addr[7:0] <= next_byte;
        default: opcode <= opcode;
      endcase
    end
  end

  // Read kinds within the current frame.
  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      read_on <= 1'b0;
      rdsr_on <= 1'b0;
    end else if (shift_rise && bit_cnt == PPC_CNT_OPCODE && !byte_refused) begin
      read_on <= (next_byte == PPC_OP_READ);
      rdsr_on <= (next_byte == PPC_OP_RDSR);
    end
  end

  // End-of-frame checks and command decode.
  always_comb begin
    frame_end = cs_rise && (seq == PPC_SEQ_SHIFT) && !cs_prev && cs_armed && !paused;
    case (opcode)
      PPC_OP_SET_WRITE_LATCH_CMD, PPC_OP_WRDI, PPC_OP_DPD, PPC_OP_REL, PPC_OP_CLRF, PPC_OP_SRST: begin
        len_ok = (bit_cnt == PPC_LEN_SHORT);
      end
      PPC_OP_WRSR: len_ok = (bit_cnt == PPC_LEN_WRSR);
      PPC_OP_ERASE: len_ok = (bit_cnt == PPC_LEN_ERASE);
      PPC_OP_WRITE: begin
        len_ok = (bit_cnt >= PPC_LEN_WRITE_MIN) && (bit_cnt[2:0] == 3'h0);
      end
      default: len_ok = 1'b0;
    endcase
    go = frame_end && len_ok;
    modify_ok = go && write_enable_latch;
    do_set_write_latch_cmd = go && (opcode == PPC_OP_SET_WRITE_LATCH_CMD);
    do_wrdi = go && (opcode == PPC_OP_WRDI);
    do_dpd = go && (opcode == PPC_OP_DPD);
    do_rel = go && (opcode == PPC_OP_REL);
    do_clr = go && (opcode == PPC_OP_CLRF);
    do_srst = go && (opcode == PPC_OP_SRST);
    start_write = modify_ok && (opcode == PPC_OP_WRITE) && !gif.target_guarded;
    start_erase = modify_ok && (opcode == PPC_OP_ERASE) && gif.erase_allowed;
    start_wrsr = modify_ok && (opcode == PPC_OP_WRSR)
                 && !(lock_sampled && !wp_sampled);
    guard_hit = modify_ok && (((opcode == PPC_OP_WRITE) && gif.target_guarded)
                 || ((opcode == PPC_OP_ERASE) && !gif.erase_allowed));
  end

  // Modify cycle engine; runs regardless of pause or deselection.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      modify_busy <= PPC_BUSY_RST;
      mod_cnt <= 32'h0000_0000;
      kind <= PPC_KIND_WRITE;
    end else if (start_write || start_erase || start_wrsr) begin
      modify_busy <= 1'b1;
      mod_cnt <= 32'h0000_0000;
      kind <= start_wrsr ? PPC_KIND_STATUS : (start_erase ? PPC_KIND_ERASE : PPC_KIND_WRITE);
    end else if (mod_done) begin
      modify_busy <= 1'b0;
    end else if (modify_busy) begin
      mod_cnt <= mod_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      array_write_start <= 1'b0;
      array_erase_start <= 1'b0;
      array_addr <= '0;
    end else begin
      array_write_start <= start_write;
      array_erase_start <= start_erase;
      if (start_write || start_erase) begin
        array_addr <= addr;
      end
    end
  end

  // Write enable latch.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_enable_latch <= PPC_WEL_RST;
    end else if (do_wrdi || mod_done) begin
      write_enable_latch <= 1'b0;
    end else if (do_set_write_latch_cmd) begin
      write_enable_latch <= 1'b1;
    end
  end

  // Nonvolatile status bits: reloaded from storage, written at status-write end.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      {status_lock, guard_from_low_end, block_guard_hi, block_guard_mid, block_guard_lo}
        <= nv_stored;
      nv_store <= 1'b0;
    end else begin
      nv_store <= mod_done && (kind == PPC_KIND_STATUS);
      if (mod_done && kind == PPC_KIND_STATUS) begin
        status_lock <= wrsr_data[PPC_ST_LOCK];
        guard_from_low_end <= wrsr_data[PPC_ST_LOW_END];
        {block_guard_hi, block_guard_mid, block_guard_lo}
          <= wrsr_data[PPC_ST_GUARD_HI:PPC_ST_GUARD_LO];
      end
    end
  end

  // Power state.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pwr <= PPC_PWR_STANDBY;
    end else if (do_dpd) begin
      pwr <= PPC_PWR_DEEP;
    end else if (pwr == PPC_PWR_DEEP && !do_rel) begin
      pwr <= PPC_PWR_DEEP;
    end else if (!s_cs_n || modify_busy || start_write || start_erase || start_wrsr) begin
      pwr <= PPC_PWR_ACTIVE;
    end else begin
      pwr <= PPC_PWR_STANDBY;
    end
  end

  assign power_state = pwr;

  // Volatile configuration and safety bits; a new event wins over a clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buffer_load_select <= PPC_BUF_LOAD_RST;
    end else if (do_srst) begin
      buffer_load_select <= PPC_BUF_LOAD_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      guard_violation_flag <= PPC_FLAG_RST;
    end else if (guard_hit) begin
      guard_violation_flag <= 1'b1;
    end else if (do_clr || do_srst) begin
      guard_violation_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ecc_one_flag <= PPC_FLAG_RST;
      ecc_two_flag <= PPC_FLAG_RST;
      ecc_three_flag <= PPC_FLAG_RST;
    end else begin
      if (read_on && ecc_fix_one) begin
        ecc_one_flag <= 1'b1;
      end else if (do_clr || do_srst) begin
        ecc_one_flag <= 1'b0;
      end
      if (read_on && ecc_fix_two) begin
        ecc_two_flag <= 1'b1;
      end else if (do_clr || do_srst) begin
        ecc_two_flag <= 1'b0;
      end
      if (read_on && ecc_detect_three) begin
        ecc_three_flag <= 1'b1;
      end else if (do_clr || do_srst) begin
        ecc_three_flag <= 1'b0;
      end
    end
  end

  // Marks the current read frame as having passed a word without correction.
  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      ecc_pass_raw <= 1'b0;
    end else if (read_on && ecc_detect_three) begin
      ecc_pass_raw <= 1'b1;
    end
  end

  // Status read output, shifted out on falling clock edges after the opcode.
  always_comb begin
    status_byte = 8'h00;
    status_byte[PPC_ST_LOCK] = status_lock;
    status_byte[PPC_ST_LOW_END] = guard_from_low_end;
    status_byte[PPC_ST_GUARD_HI:PPC_ST_GUARD_LO] =
      {block_guard_hi, block_guard_mid, block_guard_lo};
    status_byte[PPC_ST_WEL] = write_enable_latch;
    status_byte[PPC_ST_BUSY] = modify_busy;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || s_cs_n) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= rdsr_on && !paused && (s_pause_n || s_sclk);
      if (sclk_fall && rdsr_on && !paused) begin
        serial_out <= status_byte[3'h7 - bit_cnt[2:0]];
      end
    end
  end
endmodule // ppc_ctrl

// [test/ppc_ctrl_properties.sv]
// Port-level checker for the power and protection controller.
module ppc_ctrl_properties
  import ppc_pkg::*;
#(
  parameter int MODIFY_CYCLES = PPC_MODIFY_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_sel_n,
  input wire logic [1:0] power_state,
  input wire logic write_enable_latch,
  input wire logic modify_busy,
  input wire logic serial_out_oe,
  input wire logic paused,
  input wire logic block_guard_hi,
  input wire logic block_guard_mid,
  input wire logic block_guard_lo,
  input wire logic guard_from_low_end,
  input wire logic buffer_load_select,
  input wire logic array_write_start,
  input wire logic array_erase_start,
  input wire logic [PPC_ADDR_W-1:0] array_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic [2:0] code;
  int busy_len;
  assign code = {block_guard_hi, block_guard_mid, block_guard_lo};
  always_ff @(posedge clk_sys) begin
    busy_len <= (rst || !modify_busy) ? 0 : busy_len + 1;
  end
  function automatic logic guarded(logic [2:0] c, logic lo, logic [20:0] a);
    logic [21:0] sz;
    sz = 22'h10000 << (c - 3'h1);
    if (c == 3'h0) return 1'b0;
    if (c >= 3'h6) return 1'b1;
    return lo ? ({1'b0, a} < sz) : ({1'b0, a} >= 22'h200000 - sz);
  endfunction
  busy_len_a: assert property ($fell(modify_busy) |-> busy_len == MODIFY_CYCLES)
    else $error("busy length wrong");
  latch_clear_a: assert property ($fell(modify_busy) |-> !write_enable_latch)
    else $error("latch kept after modify");
  start_busy_a: assert property (array_write_start || array_erase_start |=> modify_busy)
    else $error("no busy after start");
  start_latch_a: assert property (array_write_start || array_erase_start |->
    write_enable_latch)
    else $error("start without latch");
  erase_guard_a: assert property (array_erase_start |-> code == PPC_GUARD_NONE)
    else $error("erase with guard set");
  write_guard_a: assert property (array_write_start |->
    !guarded(code, guard_from_low_end, array_addr))
    else $error("write into guarded area");
  busy_active_a: assert property (modify_busy |-> power_state == PPC_PWR_ACTIVE)
    else $error("not active while busy");
  deep_quiet_a: assert property (power_state == PPC_PWR_DEEP |->
    !(array_write_start || array_erase_start))
    else $error("modify in deep power-down");
  pause_float_a: assert property (paused |-> !serial_out_oe)
    else $error("output driven while paused");
  pause_select_a: assert property (chip_sel_n [*5] |-> !paused)
    else $error("paused while deselected");
  reset_state_a: assert property ($fell(rst) |-> buffer_load_select && !write_enable_latch
    && !modify_busy && power_state == PPC_PWR_STANDBY)
    else $error("bad state after reset");
endmodule // ppc_ctrl_properties

bind ppc_ctrl ppc_ctrl_properties #(.MODIFY_CYCLES(MODIFY_CYCLES)) u_props (
  .clk_sys(clk_sys), .rst(rst), .chip_sel_n(chip_sel_n), .power_state(power_state),
  .write_enable_latch(write_enable_latch), .modify_busy(modify_busy),
  .serial_out_oe(serial_out_oe), .paused(paused), .block_guard_hi(block_guard_hi),
  .block_guard_mid(block_guard_mid), .block_guard_lo(block_guard_lo),
  .guard_from_low_end(guard_from_low_end), .buffer_load_select(buffer_load_select),
  .array_write_start(array_write_start), .array_erase_start(array_erase_start),
  .array_addr(array_addr));

// [test/ppc_host_model.sv]
// Behavioural host that drives the serial pins of the controller.
module ppc_host_model (
  input wire logic clk_sys,
  output logic chip_sel_n,
  output logic serial_clk,
  output logic serial_in,
  output logic pause_n,
  output logic write_protect_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    pause_n = 1'b1;
    write_protect_n = 1'b1;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Eight system clocks per serial clock, MSB first, clock idle low.
  task automatic xfer(input logic [47:0] d, input int n, input bit keep);
    chip_sel_n <= 1'b0;
    step(4);
    for (int i = 0; i < n; i++) begin
      serial_in <= d[47-i];
      step(4);
      serial_clk <= 1'b1;
      step(4);
      serial_clk <= 1'b0;
    end
    if (!keep) begin
      finish_frame();
    end
  endtask
  // Deselect after the last rising edge; the released data line then drifts.
  task automatic finish_frame();
    step(2);
    chip_sel_n <= 1'b1;
    serial_in <= ~serial_in;
    step(8);
  endtask
  task automatic pins(input logic p, input logic w);
    pause_n <= p;
    write_protect_n <= w;
    step(6);
  endtask
endmodule // ppc_host_model

// [test/tb_top.sv]
// Self-checking bench for the power and protection controller.
module tb_top
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst, ecc_fix_one, ecc_fix_two, ecc_detect_three, serial_out, serial_out_oe;
  logic chip_sel_n, serial_clk, serial_in, pause_n, write_protect_n, nv_store, paused;
  logic write_enable_latch, modify_busy, block_guard_hi, block_guard_mid, block_guard_lo;
  logic guard_from_low_end, status_lock, buffer_load_select, guard_violation_flag;
  logic ecc_one_flag, ecc_two_flag, ecc_three_flag, ecc_pass_raw;
  logic array_write_start, array_erase_start;
  logic [1:0] power_state;
  logic [4:0] nv_stored, nv_now;
  logic [3:0] ecc_now;
  logic [20:0] array_addr;
  int errors = 0;
  int check_count = 0;
  int writes = 0;
  int erases = 0;
  assign nv_now = {status_lock, guard_from_low_end, block_guard_hi, block_guard_mid,
    block_guard_lo};
  assign ecc_now = {ecc_one_flag, ecc_two_flag, ecc_three_flag, ecc_pass_raw};
  ppc_ctrl #(.MODIFY_CYCLES(300)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .pause_n(pause_n), .write_protect_n(write_protect_n), .nv_stored(nv_stored),
    .ecc_fix_one(ecc_fix_one), .ecc_fix_two(ecc_fix_two), .ecc_detect_three(ecc_detect_three),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .power_state(power_state),
    .write_enable_latch(write_enable_latch), .modify_busy(modify_busy),
    .block_guard_hi(block_guard_hi), .block_guard_mid(block_guard_mid),
    .block_guard_lo(block_guard_lo), .guard_from_low_end(guard_from_low_end),
    .status_lock(status_lock), .nv_store(nv_store), .buffer_load_select(buffer_load_select),
    .guard_violation_flag(guard_violation_flag), .ecc_one_flag(ecc_one_flag),
    .ecc_two_flag(ecc_two_flag), .ecc_three_flag(ecc_three_flag), .ecc_pass_raw(ecc_pass_raw),
    .paused(paused), .array_write_start(array_write_start),
    .array_erase_start(array_erase_start), .array_addr(array_addr));
  ppc_host_model u_host (.clk_sys(clk_sys), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_in(serial_in), .pause_n(pause_n), .write_protect_n(write_protect_n));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (array_write_start === 1'b1) writes++;
    if (array_erase_start === 1'b1) erases++;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d check_count=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (modify_busy !== 1'b0 && k < 2000) begin
      @(posedge clk_sys);
      k++;
    end
    if (modify_busy !== 1'b0) errors++;
    step(2);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.xfer({op, 40'h0}, 8, 1'b0);
  endtask
  task automatic wrsr(input logic [7:0] v);
    wait_idle();
    cmd(PPC_OP_SET_WRITE_LATCH_CMD);
    u_host.xfer({PPC_OP_WRSR, v, 32'h0}, 16, 1'b0);
    wait_idle();
  endtask
  task automatic try_mod(input logic [7:0] op, input logic [20:0] a, input int n,
      input bit set_write_latch_cmd, input int exp_w, input int exp_e);
    int w;
    int e;
    wait_idle();
    if (set_write_latch_cmd) begin
      cmd(PPC_OP_SET_WRITE_LATCH_CMD);
    end
    w = writes;
    e = erases;
    u_host.xfer({op, 3'h0, a, 16'h5a00}, n, 1'b0);
    check(writes - w, exp_w);
    check(erases - e, exp_e);
  endtask
  task automatic test_write();
    try_mod(PPC_OP_WRITE, 21'h000100, 40, 1'b0, 0, 0);
    try_mod(PPC_OP_WRITE, 21'h000100, 41, 1'b1, 0, 0);
    try_mod(PPC_OP_WRITE, 21'h1abcd, 40, 1'b1, 1, 0);
    check(array_addr, 21'h1abcd);
    check(power_state, PPC_PWR_ACTIVE);
    cmd(PPC_OP_DPD);
    check(power_state, PPC_PWR_ACTIVE);
    u_host.xfer({PPC_OP_RDSR, 40'h0}, 16, 1'b1);
    check({serial_out_oe, serial_out}, 2'b11);
    u_host.finish_frame();
    wait_idle();
    check({power_state, write_enable_latch}, {PPC_PWR_STANDBY, 1'b0});
  endtask
  task automatic test_guard();
    logic [21:0] sz;
    for (int lo = 0; lo < 2; lo++) begin
      for (int c = 1; c < 8; c++) begin
        sz = 22'h10000 << (c - 1);
        wrsr({1'b0, lo[0], 1'b0, c[2:0], 2'b00});
        check(nv_now, {1'b0, lo[0], c[2:0]});
        try_mod(PPC_OP_WRITE, lo ? 21'h0 : 21'h1fffff, 40, 1'b1, 0, 0);
        check(guard_violation_flag, 1'b1);
        try_mod(PPC_OP_ERASE, 21'h0, 32, 1'b1, 0, 0);
        cmd(PPC_OP_CLRF);
        check(guard_violation_flag, 1'b0);
        if (c < 6) begin
          try_mod(PPC_OP_WRITE, lo ? sz[20:0] : 21'h1fffff - sz[20:0], 40, 1'b1, 1, 0);
        end
      end
    end
    wrsr(8'h80);
    check(nv_now, 5'h10);
    u_host.pins(1'b1, 1'b0);
    wrsr(8'h1c);
    check(nv_now, 5'h10);
    u_host.pins(1'b1, 1'b1);
    wrsr(8'h00);
    check(nv_now, 5'h00);
    try_mod(PPC_OP_ERASE, 21'h0, 32, 1'b1, 0, 1);
    wait_idle();
  endtask
  task automatic test_deep();
    cmd(PPC_OP_DPD);
    check(power_state, PPC_PWR_DEEP);
    try_mod(PPC_OP_WRITE, 21'h000100, 40, 1'b1, 0, 0);
    cmd(PPC_OP_REL);
    check(power_state, PPC_PWR_STANDBY);
  endtask
  task automatic test_pause();
    u_host.xfer({PPC_OP_SET_WRITE_LATCH_CMD, 40'h0}, 8, 1'b1);
    u_host.pins(1'b0, 1'b1);
    check({paused, serial_out_oe}, 2'b10);
    u_host.pins(1'b1, 1'b1);
    check(paused, 1'b0);
    u_host.pins(1'b0, 1'b1);
    u_host.finish_frame();
    u_host.pins(1'b1, 1'b1);
    check(write_enable_latch, 1'b0);
  endtask
  task automatic test_ecc();
    u_host.xfer({PPC_OP_READ, 40'h0}, 32, 1'b1);
    ecc_fix_one <= 1'b1;
    ecc_detect_three <= 1'b1;
    step(1);
    ecc_fix_one <= 1'b0;
    ecc_detect_three <= 1'b0;
    step(2);
    check(ecc_now, 4'hb);
    ecc_fix_two <= 1'b1;
    step(1);
    ecc_fix_two <= 1'b0;
    step(2);
    check(ecc_now, 4'hf);
    u_host.finish_frame();
    cmd(PPC_OP_CLRF);
    check(ecc_now, 4'h0);
  endtask
  initial begin
    rst = 1'b1;
    nv_stored = 5'h08;
    ecc_fix_one = 1'b0;
    ecc_fix_two = 1'b0;
    ecc_detect_three = 1'b0;
    step(10);
    check({nv_now, buffer_load_select, write_enable_latch, modify_busy, power_state,
      guard_violation_flag}, 11'h220);
    step(2);
    rst <= 1'b0;
    step(4);
    test_write();
    test_guard();
    test_deep();
    test_pause();
    test_ecc();
    print_verdict();
  end
  initial begin
    step(60000);
    errors++;
    print_verdict();
  end
endmodule // tb_top
